// ===== sdpc_pkg.sv
`default_nettype none
package sdpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on APB
  localparam logic [7:0] ADDR_CTRL_A = 8'h00; // Channel A control
  localparam logic [7:0] ADDR_CTRL_B = 8'h04; // Channel B control
  localparam logic [7:0] ADDR_GLOBAL = 8'h08; // Shared control
  localparam logic [7:0] ADDR_STATUS = 8'h0C; // Read-only status

  ////////////////////////////////////////////////////////////////////////////
  // Channel control fields
  localparam int CTRL_W = 8;
  localparam int CB_CODER = 0; // Coder enable, ORed with pin
  localparam int CB_PDOWN = 1; // Register power-down
  localparam int CB_LOSEN = 2; // Loss-of-signal reporting enable
  localparam int CB_COMB = 3; // Combine general input into loss
  localparam int CB_VIEW = 4; // Two bits: what the loss pin shows
  localparam int CB_SRATE = 6; // Two bits: software rate
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h04; // Reporting on by default

  // Shared control fields
  localparam int GLB_W = 5;
  localparam int GB_PAT = 0; // Pattern test enable, ORed with pin
  localparam int GB_PSEL = 1; // Three bits: pattern choice
  localparam int GB_CLKB = 4; // Software clock-output select
  localparam logic [2:0] PAT_SEL_P31 = 3'h2; // Code of the 2^31-1 sequence
  localparam logic [GLB_W-1:0] GLB_RST = {1'b0, PAT_SEL_P31, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pin vector layout
  localparam int PIN_W = 15;
  localparam int PI_CODER = 0; // Two bits
  localparam int PI_PDN = 2; // Two bits, active low
  localparam int PI_RATE_A = 4; // Three bits
  localparam int PI_RATE_B = 7; // Three bits
  localparam int PI_PAT = 10;
  localparam int PI_CLK = 11;
  localparam int PI_GPI = 12;
  localparam int PI_BELOW = 13; // Two bits, level detector
  // Power-down pins idle high so the channels start awake
  localparam logic [PIN_W-1:0] PIN_RST = 15'h000C;

  // Status word layout
  localparam int ST_LOS = 15;
  localparam int ST_PD = 17;
  localparam int ST_RATE = 19;
  localparam int ST_SRC = 23;
  localparam int ST_CLKB = 27;
  localparam int ST_PASS = 28;

  ////////////////////////////////////////////////////////////////////////////
  // Rate select codes
  typedef enum logic [2:0] {
    RS_FULL = 3'b000,
    RS_HALF = 3'b001,
    RS_QUARTER = 3'b010,
    RS_EIGHTH = 3'b011,
    RS_SOFT = 3'b100,
    RS_ARS = 3'b101,
    RS_ARS_CLK = 3'b110,
    RS_SLAVE = 3'b111
  } sdpc_rate_sel_t;

  // Serializer rate codes
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [1:0] RATE_EIGHTH = 2'h3;

  // Where the serializer settings come from
  localparam logic [1:0] SRC_PINS = 2'h0;
  localparam logic [1:0] SRC_SOFT = 2'h1;
  localparam logic [1:0] SRC_OWN_ARS = 2'h2;
  localparam logic [1:0] SRC_PEER_ARS = 2'h3;

  // Loss pin view choices
  localparam logic [1:0] VIEW_LOSS = 2'h0;
  localparam logic [1:0] VIEW_PAT_ERR = 2'h1;
  localparam logic [1:0] VIEW_CODER = 2'h2;
  localparam logic [1:0] VIEW_ARS = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    logic [PIN_W-1:0] s1; // Sync stage 1
    logic [PIN_W-1:0] s2; // Sync stage 2
    logic [PIN_W-1:0] s3; // Sync stage 3
    logic [PIN_W-1:0] pins; // Accepted pin values
    logic [1:0][CTRL_W-1:0] ctrl; // Per-channel control
    logic [GLB_W-1:0] glb; // Shared control
    logic [1:0] coder_on;
    logic [1:0] los;
    logic [1:0] los_oe;
    logic [1:0] pdown;
    logic [1:0] pat_en;
    logic [1:0] pass;
    logic [1:0] ars_run;
    logic [1:0][1:0] rate;
    logic [1:0][1:0] src;
    logic clk_b;
    logic [2:0] pat_sel;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } sdpc_state_t;

endpackage
`default_nettype wire

// ===== sdpc_top.sv
// The implementer's own choices: the APB register port and the register addresses.
`default_nettype none
module sdpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coder_enable_chan_a,
  input wire logic coder_enable_chan_b,
  input wire logic powerdown_chan_a_n,
  input wire logic powerdown_chan_b_n,
  input wire logic [2:0] rate_select_chan_a,
  input wire logic [2:0] rate_select_chan_b,
  input wire logic pattern_test_enable,
  input wire logic clk_out_select,
  input wire logic general_input_one,
  input wire logic level_below_chan_a,
  input wire logic level_below_chan_b,
  input wire logic [1:0] pattern_error,
  input wire logic [1:0] ars_rate_chan_a,
  input wire logic [1:0] ars_rate_chan_b,
  output logic signal_lost_chan_a,
  output logic signal_lost_chan_a_oe,
  output logic signal_lost_chan_b,
  output logic signal_lost_chan_b_oe,
  output logic [1:0] coder_active,
  output logic [1:0] chan_powerdown,
  output logic [1:0] ars_enable,
  output logic [1:0] serdes_rate_chan_a,
  output logic [1:0] serdes_rate_chan_b,
  output logic [1:0] rate_source_chan_a,
  output logic [1:0] rate_source_chan_b,
  output logic clk_out_chan_b,
  output logic [1:0] pattern_gen_enable,
  output logic [2:0] pattern_select,
  output logic [1:0] pattern_pass_status
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  sdpc_pkg::sdpc_state_t st_r; // Registered state
  sdpc_pkg::sdpc_state_t st_nxt; // Next state
  logic [sdpc_pkg::PIN_W-1:0] pin_raw; // Raw pins, outside the clock domain

  // Gather pins; the level detector is analog so it is synchronised too
  assign pin_raw = {level_below_chan_b, level_below_chan_a, general_input_one, clk_out_select,
                    pattern_test_enable, rate_select_chan_b, rate_select_chan_a,
                    powerdown_chan_b_n, powerdown_chan_a_n, coder_enable_chan_b, coder_enable_chan_a};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    sdpc_pkg::sdpc_rate_sel_t sel [2]; // Decoded rate selects
    logic [1:0][1:0] ars_in; // Auto rate results per channel
    logic [1:0] own_ars; // Channel runs its own auto rate sense
    logic [1:0] claim; // Channel claims the clock output
    logic [1:0] slave_lock; // Slave channel with an active peer
    logic [1:0] loss; // Loss after gating
    logic [1:0] view; // Value put on the loss pin
    logic [7:0] word; // Decoded word address
    logic hit; // Address maps to a register
    logic take; // Transfer completes this edge
    integer c;
    sel[0] = sdpc_pkg::RS_FULL;
    sel[1] = sdpc_pkg::RS_FULL;
    ars_in = {ars_rate_chan_b, ars_rate_chan_a};
    own_ars = 2'h0;
    claim = 2'h0;
    slave_lock = 2'h0;
    loss = 2'h0;
    view = 2'h0;
    word = paddr;
    hit = 1'b0;
    take = 1'b0;
    st_nxt = st_r;

    // Three-stage sync; accept a bit once stages two and three agree
    st_nxt.s1 = pin_raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (c = 0; c < sdpc_pkg::PIN_W; c++) begin
      if (st_r.s2[c] == st_r.s3[c]) begin
        st_nxt.pins[c] = st_r.s3[c];
      end
    end

    // Rate decode from accepted pins only
    sel[0] = sdpc_pkg::sdpc_rate_sel_t'(st_r.pins[sdpc_pkg::PI_RATE_A +: 3]);
    sel[1] = sdpc_pkg::sdpc_rate_sel_t'(st_r.pins[sdpc_pkg::PI_RATE_B +: 3]);
    for (c = 0; c < 2; c++) begin
      own_ars[c] = (sel[c] == sdpc_pkg::RS_ARS) || (sel[c] == sdpc_pkg::RS_ARS_CLK);
      claim[c] = (sel[c] == sdpc_pkg::RS_ARS_CLK);
    end
    // Slave follows the peer only while the peer runs auto rate sense
    slave_lock[0] = (sel[0] == sdpc_pkg::RS_SLAVE) && own_ars[1];
    slave_lock[1] = (sel[1] == sdpc_pkg::RS_SLAVE) && own_ars[0];

    // Per-channel serializer settings and pins
    for (c = 0; c < 2; c++) begin
      unique case (sel[c])
        // Fixed rates straight from the pins
        sdpc_pkg::RS_FULL: begin
          st_nxt.rate[c] = sdpc_pkg::RATE_FULL;
          st_nxt.src[c] = sdpc_pkg::SRC_PINS;
        end
        sdpc_pkg::RS_HALF: begin
          st_nxt.rate[c] = sdpc_pkg::RATE_HALF;
          st_nxt.src[c] = sdpc_pkg::SRC_PINS;
        end
        sdpc_pkg::RS_QUARTER: begin
          st_nxt.rate[c] = sdpc_pkg::RATE_QUARTER;
          st_nxt.src[c] = sdpc_pkg::SRC_PINS;
        end
        sdpc_pkg::RS_EIGHTH: begin
          st_nxt.rate[c] = sdpc_pkg::RATE_EIGHTH;
          st_nxt.src[c] = sdpc_pkg::SRC_PINS;
        end
        // Software owns the rate
        sdpc_pkg::RS_SOFT: begin
          st_nxt.rate[c] = st_r.ctrl[c][sdpc_pkg::CB_SRATE +: 2];
          st_nxt.src[c] = sdpc_pkg::SRC_SOFT;
        end
        // Own auto rate sense, with or without clock claim
        sdpc_pkg::RS_ARS, sdpc_pkg::RS_ARS_CLK: begin
          st_nxt.rate[c] = ars_in[c];
          st_nxt.src[c] = sdpc_pkg::SRC_OWN_ARS;
        end
        // Slave: peer machine if active, else registers
        sdpc_pkg::RS_SLAVE: begin
          if (slave_lock[c]) begin
            st_nxt.rate[c] = ars_in[1 - c];
            st_nxt.src[c] = sdpc_pkg::SRC_PEER_ARS;
          end else begin
            st_nxt.rate[c] = st_r.ctrl[c][sdpc_pkg::CB_SRATE +: 2];
            st_nxt.src[c] = sdpc_pkg::SRC_SOFT;
          end
        end
      endcase
      st_nxt.ars_run[c] = own_ars[c];

      // Coder: pin ORed with register bit
      st_nxt.coder_on[c] = st_r.pins[sdpc_pkg::PI_CODER + c] | st_r.ctrl[c][sdpc_pkg::CB_CODER];

      // Power-down from the active-low pin or the register bit
      st_nxt.pdown[c] = ~st_r.pins[sdpc_pkg::PI_PDN + c] | st_r.ctrl[c][sdpc_pkg::CB_PDOWN];

      // Pattern test is shared but barred per channel at eighth rate
      st_nxt.pat_en[c] = (st_r.pins[sdpc_pkg::PI_PAT] | st_r.glb[sdpc_pkg::GB_PAT])
                         & (st_nxt.rate[c] != sdpc_pkg::RATE_EIGHTH);
      // Pass falls only for as long as the checker flags errors
      st_nxt.pass[c] = ~(st_r.pat_en[c] & pattern_error[c]);

      // Level detector, gated by the reporting enable
      loss[c] = st_r.ctrl[c][sdpc_pkg::CB_LOSEN] & st_r.pins[sdpc_pkg::PI_BELOW + c];
      // Combined mode: general input low asserts, high releases
      if (st_r.ctrl[c][sdpc_pkg::CB_COMB]) begin
        loss[c] = ~st_r.pins[sdpc_pkg::PI_GPI];
      end

      // Loss pin may carry another internal function instead
      unique case (st_r.ctrl[c][sdpc_pkg::CB_VIEW +: 2])
        sdpc_pkg::VIEW_LOSS: view[c] = loss[c];
        sdpc_pkg::VIEW_PAT_ERR: view[c] = ~st_r.pass[c];
        sdpc_pkg::VIEW_CODER: view[c] = st_r.coder_on[c];
        sdpc_pkg::VIEW_ARS: view[c] = st_r.ars_run[c];
      endcase
      st_nxt.los[c] = view[c];
      // Floats while powered down; otherwise always driven
      st_nxt.los_oe[c] = ~st_nxt.pdown[c];
    end

    // Clock output: a claiming channel wins, then a locked slave pair, then the select
    if (claim[0]) begin
      st_nxt.clk_b = 1'b0;
    end else if (claim[1]) begin
      st_nxt.clk_b = 1'b1;
    end else if (slave_lock[0]) begin
      st_nxt.clk_b = 1'b1;
    end else if (slave_lock[1]) begin
      st_nxt.clk_b = 1'b0;
    end else begin
      // Pin ORed with software bit, so the pin must sit low for software control
      st_nxt.clk_b = st_r.pins[sdpc_pkg::PI_CLK] | st_r.glb[sdpc_pkg::GB_CLKB];
    end
    st_nxt.pat_sel = st_r.glb[sdpc_pkg::GB_PSEL +: 3];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave with no wait state; read data comes from a flop loaded in the setup cycle
    hit = (word == sdpc_pkg::ADDR_CTRL_A) || (word == sdpc_pkg::ADDR_CTRL_B) ||
          (word == sdpc_pkg::ADDR_GLOBAL) || (word == sdpc_pkg::ADDR_STATUS);
    take = psel & penable & st_r.ready;
    st_nxt.ready = psel & ~penable;
    st_nxt.slverr = psel & ~penable & ~hit;
    if (psel & ~penable) begin
      // Capture read data in the setup cycle
      unique case (word)
        sdpc_pkg::ADDR_CTRL_A: st_nxt.rdata = 32'(st_r.ctrl[0]);
        sdpc_pkg::ADDR_CTRL_B: st_nxt.rdata = 32'(st_r.ctrl[1]);
        sdpc_pkg::ADDR_GLOBAL: st_nxt.rdata = 32'(st_r.glb);
        sdpc_pkg::ADDR_STATUS: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[sdpc_pkg::PIN_W-1:0] = st_r.pins;
          st_nxt.rdata[sdpc_pkg::ST_LOS +: 2] = st_r.los;
          st_nxt.rdata[sdpc_pkg::ST_PD +: 2] = st_r.pdown;
          st_nxt.rdata[sdpc_pkg::ST_RATE +: 4] = st_r.rate;
          st_nxt.rdata[sdpc_pkg::ST_SRC +: 4] = st_r.src;
          st_nxt.rdata[sdpc_pkg::ST_CLKB] = st_r.clk_b;
          st_nxt.rdata[sdpc_pkg::ST_PASS +: 2] = st_r.pass;
        end
        default: st_nxt.rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
    // Writes land on the completing edge; only byte lane 0 holds bits
    if (take & pwrite & pstrb[0]) begin
      unique case (word)
        sdpc_pkg::ADDR_CTRL_A: st_nxt.ctrl[0] = pwdata[sdpc_pkg::CTRL_W-1:0];
        sdpc_pkg::ADDR_CTRL_B: st_nxt.ctrl[1] = pwdata[sdpc_pkg::CTRL_W-1:0];
        sdpc_pkg::ADDR_GLOBAL: st_nxt.glb = pwdata[sdpc_pkg::GLB_W-1:0];
        default: ; // Status is read-only, unmapped ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset drives loss pins low and enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.s1 <= sdpc_pkg::PIN_RST;
      st_r.s2 <= sdpc_pkg::PIN_RST;
      st_r.s3 <= sdpc_pkg::PIN_RST;
      st_r.pins <= sdpc_pkg::PIN_RST;
      st_r.ctrl <= {sdpc_pkg::CTRL_RST, sdpc_pkg::CTRL_RST};
      st_r.glb <= sdpc_pkg::GLB_RST;
      st_r.pat_sel <= sdpc_pkg::PAT_SEL_P31;
      st_r.pass <= 2'h3;
      st_r.los <= 2'h0;
      st_r.los_oe <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slverr;
  assign signal_lost_chan_a = st_r.los[0];
  assign signal_lost_chan_a_oe = st_r.los_oe[0];
  assign signal_lost_chan_b = st_r.los[1];
  assign signal_lost_chan_b_oe = st_r.los_oe[1];
  assign coder_active = st_r.coder_on;
  assign chan_powerdown = st_r.pdown;
  assign ars_enable = st_r.ars_run;
  assign serdes_rate_chan_a = st_r.rate[0];
  assign serdes_rate_chan_b = st_r.rate[1];
  assign rate_source_chan_a = st_r.src[0];
  assign rate_source_chan_b = st_r.src[1];
  assign clk_out_chan_b = st_r.clk_b;
  assign pattern_gen_enable = st_r.pat_en;
  assign pattern_select = st_r.pat_sel;
  assign pattern_pass_status = st_r.pass;

endmodule
`default_nettype wire

// ===== sdpc_sva.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Port-level checks on the pin control block
module sdpc_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] pattern_error,
  input wire logic [1:0] pattern_gen_enable,
  input wire logic [1:0] pattern_pass_status,
  input wire logic [1:0] serdes_rate_chan_a,
  input wire logic [1:0] ars_enable,
  input wire logic [1:0] rate_source_chan_a,
  input wire logic [1:0] chan_powerdown,
  input wire logic signal_lost_chan_a,
  input wire logic signal_lost_chan_a_oe,
  input wire logic signal_lost_chan_b_oe
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase, then a one-cycle ready pulse
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pulse_s;
    pready ##1 !pready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (setup_s |=> pulse_s) else $error("ready not a one-cycle pulse");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  hole_err_a: assert property (setup_s and paddr > 8'h0C |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  eighth_nopat_a: assert property (serdes_rate_chan_a == 2'h3 |-> !pattern_gen_enable[0])
    else $error("pattern test at eighth rate");
  pass_drop_a: assert property (pattern_gen_enable[0] && pattern_error[0] ##1 pattern_gen_enable[0]
    |-> !pattern_pass_status[0]) else $error("pass kept high on error");
  pass_idle_a: assert property (!pattern_gen_enable[1] && $past(!pattern_gen_enable[1])
    |-> pattern_pass_status[1]) else $error("pass low while idle");
  own_src_a: assert property (ars_enable[0] |-> rate_source_chan_a == sdpc_pkg::SRC_OWN_ARS)
    else $error("own rate sense not the source");
  peer_src_a: assert property (rate_source_chan_a == sdpc_pkg::SRC_PEER_ARS |-> ars_enable[1] && !ars_enable[0])
    else $error("peer source without peer sense");
  pd_float_a: assert property (signal_lost_chan_a_oe == !chan_powerdown[0])
    else $error("loss pin A drive wrong");
  pd_floatb_a: assert property (signal_lost_chan_b_oe == !chan_powerdown[1])
    else $error("loss pin B drive wrong");
  // Reset itself is the case here, so no disable
  reset_low_a: assert property (disable iff (1'b0) !presetn |-> !signal_lost_chan_a && signal_lost_chan_a_oe)
    else $error("loss pin not driven low in reset");
endmodule
bind sdpc_top sdpc_sva chk_u (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .pattern_error, .pattern_gen_enable, .pattern_pass_status, .serdes_rate_chan_a, .ars_enable,
  .rate_source_chan_a, .chan_powerdown, .signal_lost_chan_a, .signal_lost_chan_a_oe, .signal_lost_chan_b_oe);
`default_nettype wire

// ===== sdpc_straps.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Board straps: passes the wanted codes but keeps the board rules
module sdpc_straps (
  input wire logic [2:0] want_a,
  input wire logic [2:0] want_b,
  input wire logic want_clk_b,
  input wire logic sw_clk,
  output logic [2:0] rate_select_chan_a,
  output logic [2:0] rate_select_chan_b,
  output logic clk_out_select
);
  // Strap decode, purely combinational like resistors
  always_comb begin
    rate_select_chan_a = want_a;
    rate_select_chan_b = want_b;
    // Only one channel may claim the clock output
    if (want_a == 3'h6 && want_b == 3'h6) begin
      rate_select_chan_b = 3'h5;
    end
    // Two slaves would follow nothing
    if (want_a == 3'h7 && want_b == 3'h7) begin
      rate_select_chan_b = 3'h0;
    end
    // Software clock choice needs the pin tied low
    clk_out_select = sw_clk ? 1'b0 : want_clk_b;
  end
endmodule
`default_nettype wire

// ===== sdpc_tb_top.sv
`default_nettype none
module sdpc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // One row per rate code: expected rate, source, own sense, clock pick
  typedef struct packed {
    logic [2:0] code;
    logic [1:0] rate;
    logic [1:0] src;
    logic auto_rate_sense;
    logic clk;
  } sdpc_row_t;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, clk_out_select, clk_out_chan_b;
  logic coder_enable_chan_a = 1'b0, coder_enable_chan_b = 1'b0, powerdown_chan_a_n = 1'b1, powerdown_chan_b_n = 1'b1;
  logic pattern_test_enable = 1'b0, general_input_one = 1'b0, level_below_chan_a = 1'b0, level_below_chan_b = 1'b0;
  logic want_clk_b = 1'b0, sw_clk = 1'b0;
  logic [2:0] want_a = 3'h0, want_b = 3'h0, rate_select_chan_a, rate_select_chan_b, pattern_select;
  logic [1:0] pattern_error = 2'h0, ars_rate_chan_a = 2'h1, ars_rate_chan_b = 2'h2;
  logic signal_lost_chan_a, signal_lost_chan_a_oe, signal_lost_chan_b, signal_lost_chan_b_oe;
  logic [1:0] coder_active, chan_powerdown, ars_enable, serdes_rate_chan_a, serdes_rate_chan_b;
  logic [1:0] rate_source_chan_a, rate_source_chan_b, pattern_gen_enable, pattern_pass_status;
  int n_fail = 0, n_tests = 0;
  // Software rate is 2 and own sense reports 1, so the sources differ
  sdpc_row_t rows [8] = '{'{3'h0, 2'h0, 2'h0, 1'b0, 1'b1}, '{3'h1, 2'h1, 2'h0, 1'b0, 1'b1},
    '{3'h2, 2'h2, 2'h0, 1'b0, 1'b1}, '{3'h3, 2'h3, 2'h0, 1'b0, 1'b1}, '{3'h4, 2'h2, 2'h1, 1'b0, 1'b1},
    '{3'h5, 2'h1, 2'h2, 1'b1, 1'b1}, '{3'h6, 2'h1, 2'h2, 1'b1, 1'b0}, '{3'h7, 2'h2, 2'h1, 1'b0, 1'b1}};
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 pclk = ~pclk;
  sdpc_straps strap_u (.want_a, .want_b, .want_clk_b, .sw_clk, .rate_select_chan_a, .rate_select_chan_b,
    .clk_out_select);
  sdpc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .coder_enable_chan_a, .coder_enable_chan_b, .powerdown_chan_a_n, .powerdown_chan_b_n, .rate_select_chan_a,
    .rate_select_chan_b, .pattern_test_enable, .clk_out_select, .general_input_one, .level_below_chan_a,
    .level_below_chan_b, .pattern_error, .ars_rate_chan_a, .ars_rate_chan_b, .signal_lost_chan_a,
    .signal_lost_chan_a_oe, .signal_lost_chan_b, .signal_lost_chan_b_oe, .coder_active, .chan_powerdown,
    .ars_enable, .serdes_rate_chan_a, .serdes_rate_chan_b, .rate_source_chan_a, .rate_source_chan_b,
    .clk_out_chan_b, .pattern_gen_enable, .pattern_select, .pattern_pass_status);
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Wide enough for an error flag beside a full data word
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // APB transfer; ready and data taken at the rising edge, released right after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", n < 20, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(nm, {err, rd}, {e, exp});
  endtask
  // Pins need five edges through the synchroniser; eight gives margin
  task automatic settle();
    repeat (8) @(posedge pclk);
    @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
  initial begin
    // Falling edge at time zero fires the asynchronous reset
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    @(negedge pclk);
    chk("los_rst", {signal_lost_chan_a_oe, signal_lost_chan_a, signal_lost_chan_b_oe, signal_lost_chan_b}, 4'hA);
    chk("pat_rst", {pattern_pass_status, pattern_select}, 5'h1A);
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl_a", sdpc_pkg::ADDR_CTRL_A, 32'h4, 1'b0);
    rdchk("glb", sdpc_pkg::ADDR_GLOBAL, 32'h4, 1'b0);
    rdchk("hole", 8'h10, 32'h0, 1'b1);
    apb(1'b1, sdpc_pkg::ADDR_CTRL_A, 32'h84);
    pattern_test_enable <= 1'b1;
    want_clk_b <= 1'b1;
    // Every rate code on channel A, peer idle at full rate
    foreach (rows[i]) begin
      @(posedge pclk);
      want_a <= rows[i].code;
      settle();
      chk("rate_src", {serdes_rate_chan_a, rate_source_chan_a}, {rows[i].rate, rows[i].src});
      chk("ars_clk", {ars_enable[0], clk_out_chan_b, pattern_gen_enable[0]},
        {rows[i].auto_rate_sense, rows[i].clk, rows[i].rate != 2'h3});
    end
    // Slave locked onto the peer's sense
    @(posedge pclk);
    want_b <= 3'h5;
    want_clk_b <= 1'b0;
    settle();
    chk("slave", {serdes_rate_chan_a, rate_source_chan_a, clk_out_chan_b}, 5'h17);
    chk("own_b", {serdes_rate_chan_b, rate_source_chan_b}, 4'hA);
    // Both ask to claim the clock; the straps keep one claimant
    @(posedge pclk);
    want_a <= 3'h6;
    want_b <= 3'h6;
    settle();
    chk("claim", {ars_enable, clk_out_chan_b}, 3'h6);
    @(posedge pclk);
    want_a <= 3'h0;
    want_b <= 3'h0;
    sw_clk <= 1'b1;
    pattern_test_enable <= 1'b0;
    level_below_chan_a <= 1'b1;
    apb(1'b1, sdpc_pkg::ADDR_GLOBAL, 32'h14);
    settle();
    chk("sw_clk", {clk_out_chan_b, signal_lost_chan_a}, 2'h3);
    apb(1'b1, sdpc_pkg::ADDR_CTRL_A, 32'h80);
    settle();
    chk("los_off", signal_lost_chan_a, 1'b0);
    // General input replaces the detector when combined
    apb(1'b1, sdpc_pkg::ADDR_CTRL_A, 32'h8C);
    for (int g = 0; g < 2; g++) begin
      @(posedge pclk);
      general_input_one <= g[0];
      settle();
      chk("comb", signal_lost_chan_a, !g[0]);
    end
    // Coder by pin, by register, then neither, seen on the loss pin too
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      coder_enable_chan_a <= (k == 0);
      apb(1'b1, sdpc_pkg::ADDR_CTRL_A, 32'hA4 | (k == 1));
      settle();
      chk("coder", {coder_active[0], signal_lost_chan_a}, {2{k < 2}});
    end
    @(posedge pclk);
    powerdown_chan_a_n <= 1'b0;
    settle();
    chk("pd_pin", {chan_powerdown[0], signal_lost_chan_a_oe}, 2'h2);
    @(posedge pclk);
    powerdown_chan_a_n <= 1'b1;
    settle();
    chk("pd_off", {chan_powerdown[0], signal_lost_chan_a_oe}, 2'h1);
    apb(1'b1, sdpc_pkg::ADDR_CTRL_A, 32'h84);
    apb(1'b1, sdpc_pkg::ADDR_CTRL_B, 32'h06);
    settle();
    chk("pd_reg", {chan_powerdown[1], signal_lost_chan_b_oe}, 2'h2);
    apb(1'b1, sdpc_pkg::ADDR_CTRL_B, 32'h04);
    apb(1'b1, sdpc_pkg::ADDR_GLOBAL, 32'h0B);
    settle();
    chk("pat_reg", {pattern_gen_enable, pattern_select}, 5'h1D);
    @(posedge pclk);
    pattern_error <= 2'h1;
    settle();
    chk("pass", pattern_pass_status, 2'h2);
    summarize();
  end
endmodule
`default_nettype wire
